// [include/lprs_pkg.sv]
// Purpose: Shared constants and types for the low-power and reset status block.
// Assumes: Single clock domain at 40 MHz, byte-wide register port.
// Notes: Register offsets are byte addresses on the plain register port.
package lprs_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [15:0] ADDR_BREAK_STATUS = 16'hFE00;
    localparam logic [15:0] ADDR_RESET_CAUSE = 16'hFE01;
    localparam logic [15:0] ADDR_UNUSED = 16'hFE02;
    localparam logic [15:0] ADDR_BREAK_FLAG_CONTROL = 16'hFE03;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_BREAK_EXIT_WAIT = 1;
    localparam int BIT_BREAK_CLEAR_ENABLE = 7;
    localparam int BIT_RC_POWER_ON = 7;
    localparam int BIT_RC_PIN = 6;
    localparam int BIT_RC_WATCHDOG = 5;
    localparam int BIT_RC_ILLEGAL_OPCODE = 4;
    localparam int BIT_RC_ILLEGAL_ADDRESS = 3;
    localparam int BIT_RC_LOW_VOLTAGE = 1;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [7:0] RESET_CAUSE_POR = 8'h80;
    localparam logic [7:0] RESET_BYTE_ZERO = 8'h00;
    localparam int RECOVERY_WIDTH = 13;
    localparam logic [12:0] RECOVERY_LONG_CYCLES = 13'h1000;
    localparam logic [12:0] RECOVERY_SHORT_CYCLES = 13'h0020;

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    typedef enum logic [3:0] {
        LPRS_RUN = 4'h1,
        LPRS_WAIT = 4'h2,
        LPRS_STOP = 4'h4,
        LPRS_RECOVER = 4'h8
    } lprs_state_t;

endpackage : lprs_pkg

// [verilog/lprs_recovery_counter.sv]
// Purpose: Thirteen-bit recovery counter stepped on the falling crystal clock edge.
// Assumes: Clear is held from stop entry until recovery begins.
// Notes: Done is a combinational level, gated by clear, while the registered count equals the selected target.
module lprs_recovery_counter (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_short,
    output logic o_done
);

    typedef struct packed {
        logic [12:0] count;
    } lprs_cnt_state_t;

    lprs_cnt_state_t state_reg;
    lprs_cnt_state_t state_next;
    logic [12:0] target;

    always_comb begin
        target = i_short ? lprs_pkg::RECOVERY_SHORT_CYCLES : lprs_pkg::RECOVERY_LONG_CYCLES;
        state_next = state_reg;
        if (i_clear) begin
            state_next.count = 13'h0000;
        end else if (state_reg.count != target) begin
            state_next.count = state_reg.count + 13'h0001;
        end
    end

    // ----------------------------------------
    // Falling-edge counter
    // ----------------------------------------
    always_ff @(negedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_done = !i_clear && (state_reg.count == target);

    a_count_held: assert property (@(negedge i_core_clk) disable iff (i_rst)
        i_clear |=> state_reg.count == 13'h0000)
        else $error("Counter not held clear.");

endmodule : lprs_recovery_counter

// [verilog/lprs_reset_cause.sv]
// Purpose: Reset cause flags, cleared by a read and set by reset events.
// Assumes: Event inputs are one-cycle pulses from reset sources.
// Notes: A new event in a read cycle wins over the clear.
module lprs_reset_cause (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_por,
    input wire logic i_pin,
    input wire logic i_watchdog,
    input wire logic i_illegal_opcode,
    input wire logic i_illegal_fetch,
    input wire logic i_low_voltage,
    input wire logic i_read_clear,
    output logic [7:0] o_flags
);

    typedef struct packed {
        logic [7:0] flags;
    } lprs_rc_state_t;

    lprs_rc_state_t state_reg;
    lprs_rc_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (i_read_clear) begin
            state_next.flags = lprs_pkg::RESET_BYTE_ZERO;
        end
        if (i_por) begin
            state_next.flags = lprs_pkg::RESET_CAUSE_POR;
        end else begin
            if (i_pin) begin
                state_next.flags[lprs_pkg::BIT_RC_PIN] = 1'b1;
            end
            if (i_watchdog) begin
                state_next.flags[lprs_pkg::BIT_RC_WATCHDOG] = 1'b1;
            end
            if (i_illegal_opcode) begin
                state_next.flags[lprs_pkg::BIT_RC_ILLEGAL_OPCODE] = 1'b1;
            end
            if (i_illegal_fetch) begin
                state_next.flags[lprs_pkg::BIT_RC_ILLEGAL_ADDRESS] = 1'b1;
            end
            if (i_low_voltage) begin
                state_next.flags[lprs_pkg::BIT_RC_LOW_VOLTAGE] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= lprs_pkg::RESET_CAUSE_POR;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_flags = state_reg.flags;

    a_por_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_por |=> o_flags == lprs_pkg::RESET_CAUSE_POR)
        else $error("Power-on did not leave only its flag.");
    a_read_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_read_clear && !(i_por || i_pin || i_watchdog || i_illegal_opcode || i_illegal_fetch || i_low_voltage)
        |=> o_flags == 8'h00)
        else $error("Read did not clear flags.");
    a_wdog_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_watchdog && !i_por |=> o_flags[lprs_pkg::BIT_RC_WATCHDOG])
        else $error("Watchdog flag missing.");

endmodule : lprs_reset_cause

// [verilog/lprs_top.sv]
// Purpose: Stop and wait sequencing, clock gating and status registers.
// Assumes: All inputs synchronous to i_core_clk; sleep commands are pulses.
// Notes: Reads return data one cycle after the read strobe.
//
// Local design decision: strobed register access.

// Contract
// - Stop entry clears counter, gates clocks.
// - Peripheral interrupt wakes from stop.
// - Stacking waits for recovery delay.
// - Any reset ends stop.
// - Both clock outputs off in stop.
// - Recovery 4096 cycles, or 32 short.
// - Break inactive in stop, registers kept.
// - Counter held clear until recovery begins.
// - Wait ends on pin, interrupt, break.
// - Three registers at fixed addresses.
// - Break-exit-wait flag set, write-zero clear.
// - Reset cause read clears six flags.
// - Power-on sets only power-on flag.
// - Pin reset sets pin flag.
// - Watchdog reset sets watchdog flag.
// - Illegal opcode sets its flag.
// - Only illegal fetches set address flag.
// - Low voltage sets its flag.
// - Break-state clears need clear-enable bit; reset cause read clears without it.
// - Counter 13 bits, falling edge.
// - Stop or wait clears interrupt mask.
// - Break during wait sets exit flag.
module lprs_top (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_stop_cmd,
    input wire logic i_wait_cmd,
    input wire logic i_irq,
    input wire logic i_break_irq,
    input wire logic i_break_state,
    input wire logic i_short_recovery_option,
    input wire logic i_reset_pin,
    input wire logic i_por,
    input wire logic i_watchdog_reset,
    input wire logic i_illegal_opcode_reset,
    input wire logic i_illegal_fetch_reset,
    input wire logic i_illegal_data_access,
    input wire logic i_low_voltage_reset,
    input wire logic i_any_reset,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_crystal_clock_en,
    output logic o_base_clock_en,
    output logic o_cpu_clock_en,
    output logic o_break_enable,
    output logic o_stack_start,
    output logic o_clear_imask,
    output logic o_sleep_exit_event,
    output logic o_flag_clear_allowed
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        lprs_pkg::lprs_state_t mode;
        logic break_exit_wait_flag;
        logic break_clear_enable;
        logic [7:0] rdata;
        logic crystal_en;
        logic base_en;
        logic cpu_en;
        logic break_en;
        logic stack_start;
        logic clear_imask;
        logic exit_event;
        logic clear_allowed;
    } lprs_top_state_t;

    lprs_top_state_t state_reg;
    lprs_top_state_t state_next;
    logic recovery_done;
    logic [7:0] cause_flags;
    logic cause_read;
    logic counter_clear;
    logic wait_exit;

    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] base);
        addr_hit = (a == base);
    endfunction : addr_hit

    assign cause_read = i_rd && addr_hit(i_addr, lprs_pkg::ADDR_RESET_CAUSE);
    assign counter_clear = (state_reg.mode != lprs_pkg::LPRS_RECOVER);
    assign wait_exit = i_reset_pin || i_irq || i_break_irq;

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    lprs_recovery_counter u_counter (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_clear(counter_clear),
        .i_short(i_short_recovery_option),
        .o_done(recovery_done)
    );

    lprs_reset_cause u_cause (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_por(i_por),
        .i_pin(i_reset_pin),
        .i_watchdog(i_watchdog_reset),
        .i_illegal_opcode(i_illegal_opcode_reset),
        .i_illegal_fetch(i_illegal_fetch_reset),
        .i_low_voltage(i_low_voltage_reset),
        .i_read_clear(cause_read),
        .o_flags(cause_flags)
    );

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.stack_start = 1'b0;
        state_next.clear_imask = 1'b0;
        state_next.exit_event = 1'b0;
        state_next.rdata = 8'h00;
        unique case (state_reg.mode)
            lprs_pkg::LPRS_RUN: begin
                if (i_stop_cmd) begin
                    state_next.mode = lprs_pkg::LPRS_STOP;
                    state_next.clear_imask = 1'b1;
                end else if (i_wait_cmd) begin
                    state_next.mode = lprs_pkg::LPRS_WAIT;
                    state_next.clear_imask = 1'b1;
                end
            end
            lprs_pkg::LPRS_WAIT: begin
                if (wait_exit) begin
                    state_next.mode = lprs_pkg::LPRS_RUN;
                    state_next.exit_event = 1'b1;
                    state_next.stack_start = i_irq || i_break_irq;
                end
            end
            lprs_pkg::LPRS_STOP: begin
                if (i_irq) begin
                    state_next.mode = lprs_pkg::LPRS_RECOVER;
                end
            end
            lprs_pkg::LPRS_RECOVER: begin
                if (recovery_done) begin
                    state_next.mode = lprs_pkg::LPRS_RUN;
                    state_next.stack_start = 1'b1;
                    state_next.exit_event = 1'b1;
                end
            end
        endcase
        if (i_any_reset) begin
            state_next.mode = lprs_pkg::LPRS_RUN;
            state_next.stack_start = 1'b0;
            state_next.break_exit_wait_flag = 1'b0;
        end
        state_next.crystal_en = (state_next.mode != lprs_pkg::LPRS_STOP)
            && (state_next.mode != lprs_pkg::LPRS_RECOVER);
        state_next.base_en = state_next.crystal_en;
        state_next.cpu_en = (state_next.mode == lprs_pkg::LPRS_RUN);
        state_next.break_en = state_next.crystal_en;
        if (i_wr && addr_hit(i_addr, lprs_pkg::ADDR_BREAK_STATUS)
            && !i_wdata[lprs_pkg::BIT_BREAK_EXIT_WAIT]
            && (!i_break_state || state_reg.break_clear_enable)) begin
            state_next.break_exit_wait_flag = 1'b0;
        end
        if (i_wr && addr_hit(i_addr, lprs_pkg::ADDR_BREAK_FLAG_CONTROL)) begin
            state_next.break_clear_enable = i_wdata[lprs_pkg::BIT_BREAK_CLEAR_ENABLE];
        end
        if ((state_reg.mode == lprs_pkg::LPRS_WAIT) && i_break_irq && !i_any_reset) begin
            state_next.break_exit_wait_flag = 1'b1;
        end
        state_next.clear_allowed = !i_break_state || state_next.break_clear_enable;
        if (i_rd) begin
            if (addr_hit(i_addr, lprs_pkg::ADDR_BREAK_STATUS)) begin
                state_next.rdata[lprs_pkg::BIT_BREAK_EXIT_WAIT] = state_reg.break_exit_wait_flag;
            end else if (addr_hit(i_addr, lprs_pkg::ADDR_RESET_CAUSE)) begin
                state_next.rdata = cause_flags;
            end else if (addr_hit(i_addr, lprs_pkg::ADDR_BREAK_FLAG_CONTROL)) begin
                state_next.rdata[lprs_pkg::BIT_BREAK_CLEAR_ENABLE] = state_reg.break_clear_enable;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg.mode <= lprs_pkg::LPRS_RUN;
            state_reg.break_exit_wait_flag <= 1'b0;
            state_reg.break_clear_enable <= 1'b0;
            state_reg.rdata <= 8'h00;
            state_reg.crystal_en <= 1'b1;
            state_reg.base_en <= 1'b1;
            state_reg.cpu_en <= 1'b1;
            state_reg.break_en <= 1'b1;
            state_reg.stack_start <= 1'b0;
            state_reg.clear_imask <= 1'b0;
            state_reg.exit_event <= 1'b0;
            state_reg.clear_allowed <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rdata = state_reg.rdata;
    assign o_crystal_clock_en = state_reg.crystal_en;
    assign o_base_clock_en = state_reg.base_en;
    assign o_cpu_clock_en = state_reg.cpu_en;
    assign o_break_enable = state_reg.break_en;
    assign o_stack_start = state_reg.stack_start;
    assign o_clear_imask = state_reg.clear_imask;
    assign o_sleep_exit_event = state_reg.exit_event;
    assign o_flag_clear_allowed = state_reg.clear_allowed;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_stop_entry;
        state_reg.mode == lprs_pkg::LPRS_RUN && i_stop_cmd && !i_any_reset;
    endsequence

    a_stop_gates: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_stop_entry |=> !o_crystal_clock_en && !o_base_clock_en && o_clear_imask)
        else $error("Stop did not gate clocks.");
    a_stop_reset: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_any_reset |=> state_reg.mode == lprs_pkg::LPRS_RUN && o_crystal_clock_en)
        else $error("Reset did not end stop.");
    a_wait_exit: assert property (@(posedge i_core_clk) disable iff (i_rst)
        state_reg.mode == lprs_pkg::LPRS_WAIT && wait_exit |=> o_sleep_exit_event && o_cpu_clock_en)
        else $error("Wait did not end.");
    a_bw_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
        state_reg.mode == lprs_pkg::LPRS_WAIT && i_break_irq && !i_any_reset |=> state_reg.break_exit_wait_flag)
        else $error("Break exit flag not set.");
    a_stack_late: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_stack_start && $past(state_reg.mode) == lprs_pkg::LPRS_RECOVER |-> $past(recovery_done))
        else $error("Stacking before recovery.");
    a_stop_wake: assert property (@(posedge i_core_clk) disable iff (i_rst)
        state_reg.mode == lprs_pkg::LPRS_STOP && i_irq && !i_any_reset |=> state_reg.mode == lprs_pkg::LPRS_RECOVER)
        else $error("Interrupt did not wake stop.");
    a_clear_guard: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_break_state && !state_reg.break_clear_enable && !(i_wr && addr_hit(i_addr, lprs_pkg::ADDR_BREAK_FLAG_CONTROL))
        |=> !o_flag_clear_allowed)
        else $error("Flags unprotected in break.");
    a_read_latency: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_rd |=> o_rdata == 8'h00)
        else $error("Read data outside its cycle.");
    a_data_ignored: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_illegal_data_access && !i_illegal_fetch_reset && !cause_flags[lprs_pkg::BIT_RC_ILLEGAL_ADDRESS]
        |=> !cause_flags[lprs_pkg::BIT_RC_ILLEGAL_ADDRESS])
        else $error("Data access set address flag.");

endmodule : lprs_top

// [tb/lprs_cpu_model.sv]
// Purpose: Behavioural processor core, interrupt source and break source facing the sequencer.
// Assumes: Requests come from the bench as one-cycle pulses on i_go.
// Notes: The interrupt level is held until stacking or a wake event is reported.
module lprs_cpu_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_stop,
    input wire logic i_wake_break,
    input wire logic [15:0] i_delay,
    input wire logic i_stack_start,
    input wire logic i_exit,
    output logic o_stop_cmd,
    output logic o_wait_cmd,
    output logic o_irq,
    output logic o_break_irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Sleep command and delayed wake source
    // ----------------------------------------
    logic [15:0] cnt;
    logic pend;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 16'h0000;
            pend <= 1'b0;
            o_stop_cmd <= 1'b0;
            o_wait_cmd <= 1'b0;
            o_irq <= 1'b0;
            o_break_irq <= 1'b0;
        end else begin
            o_stop_cmd <= i_go && i_stop;
            o_wait_cmd <= i_go && !i_stop;
            o_break_irq <= 1'b0;
            if (i_go) begin
                cnt <= i_delay;
                pend <= 1'b1;
            end else if (pend && cnt != 16'h0000) begin
                cnt <= cnt - 16'h0001;
            end else if (pend) begin
                pend <= 1'b0;
                o_break_irq <= i_wake_break;
                o_irq <= !i_wake_break;
            end
            if (i_stack_start || i_exit) begin
                o_irq <= 1'b0;
            end
        end
    end
endmodule : lprs_cpu_model

// [tb/tb_lprs_top.sv]
// Purpose: Self-checking bench for the low-power and reset status block.
// Assumes: Clock of 25 ns, reset held for 10 cycles.
// Notes: Recovery lengths are checked against a small window after the wake request.
module tb_lprs_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 1'b0, rst = 1'b1, short_rec = 1'b0, brk_state = 1'b0;
    logic rst_pin = 1'b0, por = 1'b0, wdog = 1'b0, illegal_opcode_flag = 1'b0, illegal_address_flag = 1'b0, data_acc = 1'b0, low_voltage_cause_flag = 1'b0;
    logic any_rst = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, go_stop = 1'b0, go_brk = 1'b0;
    logic [15:0] addr = 16'h0000, go_delay = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, v;
    logic xclk_en, base_en, cpu_en, brk_en, stack, imask, exit_ev, clr_ok, stop_cmd, wait_cmd, irq, brk_irq;
    int fail_count = 0, n_tests = 0, n, i;
    typedef struct packed {logic [6:0] ev; logic [7:0] exp;} lprs_row_t;
    lprs_row_t rows [7] = '{'{7'h40, 8'h80}, '{7'h20, 8'h40}, '{7'h10, 8'h20}, '{7'h08, 8'h10},
                            '{7'h04, 8'h08}, '{7'h02, 8'h00}, '{7'h01, 8'h02}};

    lprs_top i_dut (.i_core_clk(clk), .i_rst(rst), .i_stop_cmd(stop_cmd), .i_wait_cmd(wait_cmd), .i_irq(irq),
        .i_break_irq(brk_irq), .i_break_state(brk_state), .i_short_recovery_option(short_rec),
        .i_reset_pin(rst_pin), .i_por(por), .i_watchdog_reset(wdog), .i_illegal_opcode_reset(illegal_opcode_flag),
        .i_illegal_fetch_reset(illegal_address_flag), .i_illegal_data_access(data_acc), .i_low_voltage_reset(low_voltage_cause_flag),
        .i_any_reset(any_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_crystal_clock_en(xclk_en), .o_base_clock_en(base_en), .o_cpu_clock_en(cpu_en),
        .o_break_enable(brk_en), .o_stack_start(stack), .o_clear_imask(imask),
        .o_sleep_exit_event(exit_ev), .o_flag_clear_allowed(clr_ok));
    lprs_cpu_model i_cpu (.i_core_clk(clk), .i_rst(rst), .i_go(go), .i_stop(go_stop), .i_wake_break(go_brk),
        .i_delay(go_delay), .i_stack_start(stack), .i_exit(exit_ev), .o_stop_cmd(stop_cmd),
        .o_wait_cmd(wait_cmd), .o_irq(irq), .o_break_irq(brk_irq));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    task automatic pulse_ev(input logic [6:0] ev);
        @(posedge clk);
        {por, rst_pin, wdog, illegal_opcode_flag, illegal_address_flag, data_acc, low_voltage_cause_flag} <= ev;
        any_rst <= |(ev & 7'h7D);
        @(posedge clk);
        {por, rst_pin, wdog, illegal_opcode_flag, illegal_address_flag, data_acc, low_voltage_cause_flag} <= 7'h00;
        any_rst <= 1'b0;
    endtask : pulse_ev

    task automatic sleep(input logic s, input logic b, input logic [15:0] d);
        @(posedge clk);
        go <= 1'b1;
        go_stop <= s;
        go_brk <= b;
        go_delay <= d;
        @(posedge clk);
        go <= 1'b0;
    endtask : sleep

    task automatic wait_exit(output logic seen);
        seen = 1'b0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (exit_ev === 1'b1) seen = 1'b1;
        end
    endtask : wait_exit

    task automatic measure(output int cnt);
        cnt = 0;
        repeat (200) begin
            if (irq === 1'b1) break;
            @(posedge clk);
            #1;
        end
        while (stack !== 1'b1 && cnt < 5000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask : measure

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_reg(lprs_pkg::ADDR_RESET_CAUSE, v); check(v, 8'h80);
        rd_reg(lprs_pkg::ADDR_RESET_CAUSE, v); check(v, 8'h00);
        rd_reg(lprs_pkg::ADDR_BREAK_STATUS, v); check(v, 8'h00);
        wr_reg(lprs_pkg::ADDR_BREAK_FLAG_CONTROL, 8'hFF);
        rd_reg(lprs_pkg::ADDR_BREAK_FLAG_CONTROL, v); check(v, 8'h80);
        wr_reg(lprs_pkg::ADDR_UNUSED, 8'hFF);
        rd_reg(lprs_pkg::ADDR_UNUSED, v); check(v, 8'h00);
        $display("test register map done");
        for (i = 0; i < 7; i++) begin
            pulse_ev(rows[i].ev);
            rd_reg(lprs_pkg::ADDR_RESET_CAUSE, v); check(v, rows[i].exp);
            rd_reg(lprs_pkg::ADDR_RESET_CAUSE, v); check(v, 8'h00);
        end
        pulse_ev(7'h30);
        pulse_ev(7'h40);
        rd_reg(lprs_pkg::ADDR_RESET_CAUSE, v); check(v, 8'h80);
        $display("test reset causes done");
        brk_state <= 1'b1;
        wr_reg(lprs_pkg::ADDR_BREAK_FLAG_CONTROL, 8'h00);
        repeat (2) @(posedge clk);
        #1 check({7'h00, clr_ok}, 8'h00);
        wr_reg(lprs_pkg::ADDR_BREAK_FLAG_CONTROL, 8'h80);
        repeat (2) @(posedge clk);
        #1 check({7'h00, clr_ok}, 8'h01);
        sleep(1'b0, 1'b1, 16'h0005);
        @(posedge clk);
        #1 check({6'h00, imask, cpu_en}, 8'h02);
        wait_exit(v[0]); check({7'h00, v[0]}, 8'h01);
        rd_reg(lprs_pkg::ADDR_BREAK_STATUS, v); check(v, 8'h02);
        wr_reg(lprs_pkg::ADDR_BREAK_FLAG_CONTROL, 8'h00);
        wr_reg(lprs_pkg::ADDR_BREAK_STATUS, 8'h00);
        rd_reg(lprs_pkg::ADDR_BREAK_STATUS, v); check(v, 8'h02);
        wr_reg(lprs_pkg::ADDR_BREAK_FLAG_CONTROL, 8'h80);
        wr_reg(lprs_pkg::ADDR_BREAK_STATUS, 8'h00);
        rd_reg(lprs_pkg::ADDR_BREAK_STATUS, v); check(v, 8'h00);
        brk_state <= 1'b0;
        sleep(1'b0, 1'b0, 16'h0005);
        wait_exit(v[0]); check({7'h00, v[0]}, 8'h01);
        rd_reg(lprs_pkg::ADDR_BREAK_STATUS, v); check(v, 8'h00);
        sleep(1'b0, 1'b1, 16'h0005);
        wait_exit(v[0]);
        sleep(1'b0, 1'b1, 16'h0100);
        repeat (3) @(posedge clk);
        pulse_ev(7'h20);
        repeat (2) @(posedge clk);
        #1 check({7'h00, cpu_en}, 8'h01);
        rd_reg(lprs_pkg::ADDR_BREAK_STATUS, v); check(v, 8'h00);
        $display("test wait mode done");
        short_rec <= 1'b1;
        sleep(1'b1, 1'b0, 16'h0028);
        @(posedge clk);
        #1 check({5'h00, xclk_en, base_en, brk_en}, 8'h00);
        measure(n); check({7'h00, n >= 32 && n <= 40}, 8'h01);
        repeat (2) @(posedge clk);
        #1 check({6'h00, xclk_en, base_en}, 8'h03);
        rd_reg(lprs_pkg::ADDR_BREAK_FLAG_CONTROL, v); check(v, 8'h80);
        short_rec <= 1'b0;
        sleep(1'b1, 1'b0, 16'h0008);
        measure(n); check({7'h00, n >= 4096 && n <= 4104}, 8'h01);
        $display("test stop recovery done");
        rd_reg(lprs_pkg::ADDR_RESET_CAUSE, v); check(v, 8'h40);
        short_rec <= 1'b1;
        sleep(1'b1, 1'b0, 16'hFFFF);
        repeat (3) @(posedge clk);
        pulse_ev(7'h20);
        n = 0;
        while (cpu_en !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h00, cpu_en}, 8'h01);
        rd_reg(lprs_pkg::ADDR_RESET_CAUSE, v); check(v, 8'h40);
        $display("test stop reset exit done");
        conclude();
    end
endmodule : tb_lprs_top
